// >>> sah_histogram.sv
// state activity histogram: overview buckets and range histogram behind apb
//
// Contract
// - monitored label is up to 32 channels, compared unsigned
// - exactly one label, selectable from any configured label, is sorted
// - changing label clears span, marker and range configuration and counts; changing qualifier pattern clears counts only
// - overview span split in up to 256 buckets, width rounded up
// - span below 255 values uses one bucket per value from low to high - 1; the high value gets no bucket
// - each sample increments its bucket; runs repeat until stopped or changed
// - peak tracks largest overview bucket count
// - overview total counts every sample, even outside span
// - samples outside span touch no bucket
// - two markers step by whole buckets and read bucket counts
// - up to 11 ranges with low, high, name and enable
// - range counts when enabled and low <= value <= high
// - overlapping enabled ranges all count the sample
// - disabling a range keeps its bounds and name
// - range total counts a sample at most once
// - other states included adds unmatched samples to total
// - other counter counts samples matching no enabled range
// - share is range count over total, as percentage, in software
// - qualifier pattern with don't cares covers the first label only; the other labels are don't care
// - unqualified samples are dropped before sorting
// - mode or critical variable change while running halts with warning
// - counts published after sorting an acquisition, then sampler re-armed
//
// The APB interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "sah_consts.svh"
module sah_histogram #(
    parameter int NLABELS = `SAH_NLABELS,
    parameter int LW      = `SAH_LABEL_W,
    parameter int NR      = `SAH_NRANGES,
    parameter int NB      = `SAH_NBUCKETS
) (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [11:0]           paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic [NLABELS*LW-1:0] sample_labels,
    input  wire logic                  sample_valid,
    input  wire logic                  acq_done,
    output logic                       sampler_arm,
    output logic                       run_halted
);
    import sah_pkg::*;

    sah_state_t          state_reg;
    logic                mode_reg;
    logic                other_reg;
    logic                qual_reg;
    logic                halted_reg;
    logic [1:0]          sel_reg;
    logic [LW-1:0]       low_reg;
    logic [LW-1:0]       high_reg;
    logic [7:0]          markx_reg;
    logic [7:0]          marko_reg;
    logic [NLABELS*LW-1:0] qval_reg;
    logic [NLABELS*LW-1:0] qcare_reg;
    logic [NR-1:0]       rena_reg;
    logic [LW-1:0]       rlow_reg  [NR];
    logic [LW-1:0]       rhigh_reg [NR];
    logic [31:0]         rname_reg [NR];
    logic [31:0]         rcnt_reg  [NR];
    logic [31:0]         bkt_reg   [NB];
    logic [31:0]         peak_reg;
    logic [31:0]         total_reg;
    logic [31:0]         other_cnt_reg;
    logic [31:0]         htotal_reg;
    logic [LW-1:0]       width_reg;
    logic [8:0]          nbkt_reg;
    logic [NLABELS*LW-1:0] s1_reg;
    logic [NLABELS*LW-1:0] s2_reg;
    logic                v1_reg;
    logic                v2_reg;
    logic                d1_reg;
    logic                d2_reg;

    wire logic wr = psel && penable && pwrite;
    wire logic rd_unused = 1'b0;
    wire logic running = state_reg != SAH_IDLE;

    // the bus answers at once and never reports an error
    assign pready  = 1'b1;
    assign pslverr = 1'b0;

    function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
        hit = (a == off);
    endfunction : hit

    function automatic logic in_block(input logic [11:0] a, input logic [11:0] base, input int n);
        in_block = (a >= base) && (a < base + 12'(n * 4));
    endfunction : in_block

    // control decode
    wire logic [31:0] ctrl_w   = pwdata;
    wire logic start_w = wr && hit(paddr, `SAH_OFF_CTRL) && ctrl_w[`SAH_CTRL_RUN] && !running;
    wire logic stop_w  = wr && hit(paddr, `SAH_OFF_CTRL) && !ctrl_w[`SAH_CTRL_RUN];
    wire logic mode_chg = wr && hit(paddr, `SAH_OFF_CTRL) && running
                          && (ctrl_w[`SAH_CTRL_MODE] != mode_reg
                              || ctrl_w[`SAH_CTRL_QUAL] != qual_reg
                              || ctrl_w[`SAH_CTRL_OTHER] != other_reg);
    wire logic sel_chg  = wr && hit(paddr, `SAH_OFF_SEL) && pwdata[1:0] != sel_reg;
    wire logic pat_chg  = wr && (hit(paddr, `SAH_OFF_QVAL) || hit(paddr, `SAH_OFF_QCARE));
    wire logic bnd_chg  = wr && (hit(paddr, `SAH_OFF_LOW) || hit(paddr, `SAH_OFF_HIGH));
    wire logic erase    = sel_chg || pat_chg || (wr && hit(paddr, `SAH_OFF_CTRL)
                          && ctrl_w[`SAH_CTRL_CLEAR]);
    wire logic var_chg  = running && (mode_chg || sel_chg || pat_chg || bnd_chg
                          || (wr && paddr >= `SAH_OFF_RLOW && paddr < `SAH_OFF_RCNT));
    wire logic zero_cnt = start_w || erase;

    // sampler inputs are from outside this clock
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s1_reg <= '0;
            s2_reg <= '0;
            v1_reg <= 1'b0;
            v2_reg <= 1'b0;
            d1_reg <= 1'b0;
            d2_reg <= 1'b0;
        end
        else
        begin
            s1_reg <= sample_labels;
            s2_reg <= s1_reg;
            v1_reg <= sample_valid;
            v2_reg <= v1_reg;
            d1_reg <= acq_done;
            d2_reg <= d1_reg;
        end
    end

    // selected label, any of the configured ones
    wire logic [LW-1:0] val = s2_reg[sel_reg*LW +: LW];
    wire logic qual_ok = !qual_reg || (((s2_reg ^ qval_reg) & qcare_reg) == '0);
    wire logic take = (state_reg == SAH_ARMED) && v2_reg && qual_ok;

    // bucket geometry
    wire logic [LW-1:0] span = high_reg - low_reg;
    // one spare bit: rounding up a full-range span must not wrap to a zero width
    wire logic [LW:0]   wid_w = ({1'b0, span} + (LW+1)'(NB - 1)) / (LW+1)'(NB);
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            width_reg <= LW'(1);
            nbkt_reg  <= 9'h000;
        end
        else if (span < LW'(`SAH_SMALL_SPAN))
        begin
            width_reg <= LW'(1);
            nbkt_reg  <= 9'(span);
        end
        else
        begin
            width_reg <= wid_w[LW-1:0];
            nbkt_reg  <= 9'(span / wid_w[LW-1:0]);
        end
    end

    wire logic in_span = (val >= low_reg) && (val <= high_reg);
    wire logic [LW-1:0] bidx_w = (val - low_reg) / width_reg;
    wire logic bkt_ok = in_span && (bidx_w < LW'(nbkt_reg)) && (mode_reg == SAH_OVERVIEW);

    // measurement sequence
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state_reg <= SAH_IDLE;
        else if (var_chg || stop_w)
            state_reg <= SAH_IDLE;
        else
        begin
            case (state_reg)
                SAH_IDLE:  if (start_w) state_reg <= SAH_ARMED;
                SAH_ARMED: if (d2_reg) state_reg <= SAH_SORT;
                SAH_SORT:  state_reg <= SAH_PUB;
                SAH_PUB:   state_reg <= SAH_ARMED;
                default:   state_reg <= SAH_IDLE;
            endcase
        end
    end
    assign sampler_arm = (state_reg == SAH_ARMED);
    assign run_halted  = halted_reg;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            halted_reg <= 1'b0;
        else if (var_chg)
            halted_reg <= 1'b1;
        else if (start_w)
            halted_reg <= 1'b0;
    end

    // configuration registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mode_reg  <= 1'b0;
            other_reg <= 1'b0;
            qual_reg  <= 1'b0;
            sel_reg   <= 2'h0;
            low_reg   <= '0;
            high_reg  <= LW'(`SAH_HIGH_RST);
            markx_reg <= 8'h00;
            marko_reg <= 8'h00;
            qval_reg  <= '0;
            qcare_reg <= '0;
            rena_reg  <= '0;
        end
        else if (sel_chg)
        begin
            sel_reg   <= pwdata[1:0];
            low_reg   <= '0;
            high_reg  <= LW'(`SAH_HIGH_RST);
            markx_reg <= 8'h00;
            marko_reg <= 8'h00;
            rena_reg  <= '0;
        end
        else if (wr)
        begin
            if (hit(paddr, `SAH_OFF_CTRL))
            begin
                mode_reg  <= ctrl_w[`SAH_CTRL_MODE];
                other_reg <= ctrl_w[`SAH_CTRL_OTHER];
                qual_reg  <= ctrl_w[`SAH_CTRL_QUAL];
            end
            if (hit(paddr, `SAH_OFF_LOW))   low_reg <= pwdata[LW-1:0];
            if (hit(paddr, `SAH_OFF_HIGH))  high_reg <= pwdata[LW-1:0];
            if (hit(paddr, `SAH_OFF_MARKX)) markx_reg <= pwdata[7:0];
            if (hit(paddr, `SAH_OFF_MARKO)) marko_reg <= pwdata[7:0];
            if (hit(paddr, `SAH_OFF_RENA))  rena_reg <= pwdata[NR-1:0];
            if (hit(paddr, `SAH_OFF_QVAL))
            begin
                qval_reg  <= '0;
                qval_reg[31:0] <= pwdata;
            end
            if (hit(paddr, `SAH_OFF_QCARE))
            begin
                qcare_reg <= '0;
                qcare_reg[31:0] <= pwdata;
            end
        end
    end

    // ranges and their counters
    logic [NR-1:0] match;
    genvar g;
    generate
        for (g = 0; g < NR; g++)
        begin : g_rng
            assign match[g] = rena_reg[g] && val >= rlow_reg[g] && val <= rhigh_reg[g];
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    rlow_reg[g]  <= '0;
                    rhigh_reg[g] <= '0;
                    rname_reg[g] <= 32'h0;
                end
                else if (sel_chg)
                begin
                    rlow_reg[g]  <= '0;
                    rhigh_reg[g] <= '0;
                    rname_reg[g] <= 32'h0;
                end
                else if (wr)
                begin
                    if (hit(paddr, `SAH_OFF_RLOW + 12'(g * 4)))  rlow_reg[g] <= pwdata[LW-1:0];
                    if (hit(paddr, `SAH_OFF_RHIGH + 12'(g * 4))) rhigh_reg[g] <= pwdata[LW-1:0];
                    if (hit(paddr, `SAH_OFF_RNAME + 12'(g * 4))) rname_reg[g] <= pwdata;
                end
            end
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    rcnt_reg[g] <= 32'h0;
                else if (zero_cnt)
                    rcnt_reg[g] <= 32'h0;
                else if (take && mode_reg == SAH_RANGES && match[g])
                    rcnt_reg[g] <= rcnt_reg[g] + 32'h1;
            end
        end
        for (g = 0; g < NB; g++)
        begin : g_bkt
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    bkt_reg[g] <= 32'h0;
                else if (zero_cnt)
                    bkt_reg[g] <= 32'h0;
                else if (take && bkt_ok && bidx_w == LW'(g))
                    bkt_reg[g] <= bkt_reg[g] + 32'h1;
            end
        end
    endgenerate

    wire logic any_match = |match;

    // totals and peak
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            total_reg     <= 32'h0;
            other_cnt_reg <= 32'h0;
            htotal_reg    <= 32'h0;
            peak_reg      <= 32'h0;
        end
        else if (zero_cnt)
        begin
            total_reg     <= 32'h0;
            other_cnt_reg <= 32'h0;
            htotal_reg    <= 32'h0;
            peak_reg      <= 32'h0;
        end
        else if (take)
        begin
            if (mode_reg == SAH_OVERVIEW)
            begin
                total_reg <= total_reg + 32'h1;
                if (bkt_ok && bkt_reg[bidx_w[7:0]] + 32'h1 > peak_reg)
                    peak_reg <= bkt_reg[bidx_w[7:0]] + 32'h1;
            end
            else
            begin
                if (!any_match)
                    other_cnt_reg <= other_cnt_reg + 32'h1;
                if (any_match || other_reg)
                    htotal_reg <= htotal_reg + 32'h1;
            end
        end
    end

    // read mux
    always_comb
    begin
        prdata = 32'h0;
        if (hit(paddr, `SAH_OFF_CTRL))
            prdata = {27'h0, 1'b0, qual_reg, other_reg, mode_reg, running};
        else if (hit(paddr, `SAH_OFF_STATUS))
            prdata = {29'h0, state_reg == SAH_SORT, halted_reg, running};
        else if (hit(paddr, `SAH_OFF_LOW))    prdata = 32'(low_reg);
        else if (hit(paddr, `SAH_OFF_HIGH))   prdata = 32'(high_reg);
        else if (hit(paddr, `SAH_OFF_MARKX))  prdata = {24'h0, markx_reg};
        else if (hit(paddr, `SAH_OFF_MARKO))  prdata = {24'h0, marko_reg};
        else if (hit(paddr, `SAH_OFF_QVAL))   prdata = qval_reg[31:0];
        else if (hit(paddr, `SAH_OFF_QCARE))  prdata = qcare_reg[31:0];
        else if (hit(paddr, `SAH_OFF_RENA))   prdata = 32'(rena_reg);
        else if (hit(paddr, `SAH_OFF_WIDTH))  prdata = 32'(width_reg);
        else if (hit(paddr, `SAH_OFF_NBKT))   prdata = {23'h0, nbkt_reg};
        else if (hit(paddr, `SAH_OFF_PEAK))   prdata = peak_reg;
        else if (hit(paddr, `SAH_OFF_TOTAL))  prdata = total_reg;
        else if (hit(paddr, `SAH_OFF_XCNT))   prdata = bkt_reg[markx_reg];
        else if (hit(paddr, `SAH_OFF_OCNT))   prdata = bkt_reg[marko_reg];
        else if (hit(paddr, `SAH_OFF_OTHER))  prdata = other_cnt_reg;
        else if (hit(paddr, `SAH_OFF_HTOTAL)) prdata = htotal_reg;
        else if (hit(paddr, `SAH_OFF_SEL))    prdata = {30'h0, sel_reg};
        else if (in_block(paddr, `SAH_OFF_RLOW, NR))  prdata = 32'(rlow_reg[paddr[5:2]]);
        else if (in_block(paddr, `SAH_OFF_RHIGH, NR)) prdata = 32'(rhigh_reg[paddr[5:2]]);
        else if (in_block(paddr, `SAH_OFF_RNAME, NR)) prdata = rname_reg[paddr[5:2]];
        else if (in_block(paddr, `SAH_OFF_RCNT, NR))  prdata = rcnt_reg[paddr[5:2]];
        else if (in_block(paddr, `SAH_OFF_BKT, NB))   prdata = bkt_reg[paddr[9:2]];
        else
            prdata = {31'h0, rd_unused};
    end
endmodule : sah_histogram

// >>> sah_consts.svh
// offsets, field positions, reset values and counts of the state activity histogram
`ifndef SAH_CONSTS_SVH
`define SAH_CONSTS_SVH
`define SAH_OFF_CTRL      12'h000
`define SAH_OFF_STATUS    12'h004
`define SAH_OFF_LOW       12'h008
`define SAH_OFF_HIGH      12'h00c
`define SAH_OFF_MARKX     12'h010
`define SAH_OFF_MARKO     12'h014
`define SAH_OFF_QVAL      12'h018
`define SAH_OFF_QCARE     12'h01c
`define SAH_OFF_RENA      12'h020
`define SAH_OFF_WIDTH     12'h024
`define SAH_OFF_NBKT      12'h028
`define SAH_OFF_PEAK      12'h02c
`define SAH_OFF_TOTAL     12'h030
`define SAH_OFF_XCNT      12'h034
`define SAH_OFF_OCNT      12'h038
`define SAH_OFF_OTHER     12'h03c
`define SAH_OFF_HTOTAL    12'h040
`define SAH_OFF_SEL       12'h044
`define SAH_OFF_RLOW      12'h100
`define SAH_OFF_RHIGH     12'h140
`define SAH_OFF_RNAME     12'h180
`define SAH_OFF_RCNT      12'h1c0
`define SAH_OFF_BKT       12'h400
`define SAH_CTRL_RUN      0
`define SAH_CTRL_MODE     1
`define SAH_CTRL_OTHER    2
`define SAH_CTRL_QUAL     3
`define SAH_CTRL_CLEAR    4
`define SAH_ST_ACTIVE     0
`define SAH_ST_HALTED     1
`define SAH_ST_BUSY       2
`define SAH_NBUCKETS      256
`define SAH_SMALL_SPAN    255
`define SAH_NRANGES       11
`define SAH_LABEL_W       32
`define SAH_NLABELS       4
`define SAH_HIGH_RST      32'hffffffff
`endif

// >>> sah_pkg.sv
// types of the state activity histogram
package sah_pkg;
    typedef enum logic [1:0]
    {
        SAH_IDLE  = 2'b00,
        SAH_ARMED = 2'b01,
        SAH_SORT  = 2'b10,
        SAH_PUB   = 2'b11
    } sah_state_t;
    typedef enum logic
    {
        SAH_OVERVIEW = 1'b0,
        SAH_RANGES   = 1'b1
    } sah_mode_t;
endpackage : sah_pkg

// >>> sah_histogram_checker.sv
// port assertions and covers for the state activity histogram
`timescale 1ns/1ps
`include "sah_consts.svh"
module sah_histogram_checker (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        acq_done,
    input wire logic        sampler_arm,
    input wire logic        run_halted
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire wr_acc = psel && penable && pwrite;
    wire rd_acc = psel && penable && !pwrite;
    AST_PREADY: assert property (psel && penable |-> pready)
        else $error("access phase without ready");
    AST_NO_ERR: assert property (psel && penable |-> !pslverr)
        else $error("error response seen");
    AST_UNMAPPED: assert property (rd_acc && paddr == 12'h080 |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    AST_STATUS_HALT: assert property (rd_acc && paddr == `SAH_OFF_STATUS |->
        prdata[`SAH_ST_HALTED] == run_halted) else $error("status halt bit differs");
    AST_HALT_CAUSE: assert property ($rose(run_halted) |-> $past(wr_acc))
        else $error("halt without register write");
    AST_HALT_ARM: assert property (run_halted |-> !sampler_arm)
        else $error("sampler armed while halted");
    AST_ARM_DONE: assert property (sampler_arm && acq_done |-> ##[1:5] !sampler_arm)
        else $error("sort not entered after acquisition end");
    AST_REARM: assert property ($fell(sampler_arm) && !$past(wr_acc) |->
        !sampler_arm [*2] ##[1:6] sampler_arm) else $error("sampler not re-armed");
    cover property (wr_acc && paddr == `SAH_OFF_CTRL);
    cover property ($fell(sampler_arm));
    cover property ($rose(run_halted));
endmodule : sah_histogram_checker

bind sah_histogram sah_histogram_checker i_sah_histogram_checker (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .acq_done(acq_done), .sampler_arm(sampler_arm), .run_halted(run_halted));

// >>> sah_sampler_model.sv
// state sampler model feeding label samples and acquisition ends
`timescale 1ns/1ps
module sah_sampler_model (
    input  wire logic         pclk,
    input  wire logic         sampler_arm,
    output logic      [127:0] sample_labels,
    output logic              sample_valid,
    output logic              acq_done
);
    int fails;
    initial
    begin
        sample_labels = '0;
        sample_valid = 1'b0;
        acq_done = 1'b0;
        fails = 0;
    end
    task automatic wait_arm;
        int n;
        n = 0;
        while (sampler_arm !== 1'b1 && n < 100)
        begin
            @(posedge pclk);
            n++;
        end
        if (n >= 100) fails++;
    endtask : wait_arm
    // one sample of all labels, lines scrambled while no sample is offered
    task automatic put(input logic [127:0] v);
        wait_arm();
        sample_labels <= v;
        sample_valid <= 1'b1;
        @(posedge pclk);
        sample_valid <= 1'b0;
        sample_labels <= ~v;
        @(posedge pclk);
    endtask : put
    task automatic finish;
        int n;
        n = 0;
        acq_done <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (sampler_arm !== 1'b0 && n < 20);
        if (n >= 20) fails++;
        acq_done <= 1'b0;
        repeat (8) @(posedge pclk);
        wait_arm();
    endtask : finish
endmodule : sah_sampler_model

// >>> state_activity_histogram_tb_top.sv
// self-checking testbench of the state activity histogram
`timescale 1ns/1ps
`include "sah_consts.svh"
module state_activity_histogram_tb_top;
    logic         pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic         sample_valid, acq_done, sampler_arm, run_halted;
    logic [11:0]  paddr;
    logic [31:0]  pwdata, prdata, v, q;
    logic [127:0] sample_labels;
    logic [31:0]  expq[$];
    int           errors, tests_run, seed, total, peak, other, htot, b, m0, m1;
    int           cnt[256];
    int           rc[2];
    sah_histogram i_sah_histogram (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sample_labels(sample_labels), .sample_valid(sample_valid), .acq_done(acq_done),
        .sampler_arm(sampler_arm), .run_halted(run_halted));
    sah_sampler_model i_sah_sampler_model (.pclk(pclk), .sampler_arm(sampler_arm),
        .sample_labels(sample_labels), .sample_valid(sample_valid), .acq_done(acq_done));
    initial
    begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    task automatic close_out;
        errors += i_sah_sampler_model.fails;
        if (errors == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : close_out
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    always @(posedge pclk)
        if (psel && penable && !pwrite && pready === 1'b1) chk(prdata, expq.pop_front());
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
        if (n >= 50)
        begin
            errors++;
            close_out();
        end
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        expq.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask : rd
    task automatic range_run(input logic inc);
        rc = '{0, 0};
        other = 0;
        htot = 0;
        wr(`SAH_OFF_SEL, 32'h1);
        wr(`SAH_OFF_QVAL, 32'ha5);
        wr(`SAH_OFF_QCARE, 32'hff);
        wr(`SAH_OFF_RLOW, 32'h10);
        wr(`SAH_OFF_RHIGH, 32'h1f);
        wr(`SAH_OFF_RLOW + 12'h4, 32'h18);
        wr(`SAH_OFF_RHIGH + 12'h4, 32'h27);
        wr(`SAH_OFF_RLOW + 12'h8, 32'h40);
        wr(`SAH_OFF_RHIGH + 12'h8, 32'h4f);
        wr(`SAH_OFF_RNAME, 32'h61626364);
        wr(`SAH_OFF_RENA, 32'h3);
        wr(`SAH_OFF_CTRL, {28'h0, 1'b1, inc, 2'b11});
        repeat (30)
        begin
            v = $unsigned($random(seed)) % 32'h60;
            q = $random(seed);
            if (q[0]) q[7:0] = 8'ha5;
            if (q[7:0] == 8'ha5)
            begin
                m0 = int'(v >= 32'h10 && v <= 32'h1f);
                m1 = int'(v >= 32'h18 && v <= 32'h27);
                rc[0] += m0;
                rc[1] += m1;
                other += int'(m0 + m1 == 0);
                htot += int'(m0 + m1 > 0 || inc);
            end
            i_sah_sampler_model.put({$random(seed), $random(seed), v, q});
        end
        i_sah_sampler_model.finish();
        rd(`SAH_OFF_RCNT, rc[0]);
        rd(`SAH_OFF_RCNT + 12'h4, rc[1]);
        rd(`SAH_OFF_RCNT + 12'h8, 32'h0);
        rd(`SAH_OFF_OTHER, other);
        rd(`SAH_OFF_HTOTAL, htot);
        rd(`SAH_OFF_RLOW + 12'h8, 32'h40);
        rd(`SAH_OFF_RNAME, 32'h61626364);
        wr(`SAH_OFF_CTRL, 32'h0);
    endtask : range_run
    initial
    begin
        seed = 61;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        presetn = 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(`SAH_OFF_HIGH, `SAH_HIGH_RST);
        rd(`SAH_OFF_CTRL, 32'h0);
        rd(`SAH_OFF_WIDTH, 32'h01000000);
        rd(`SAH_OFF_NBKT, 32'h000000ff);
        wr(12'h080, 32'h1234);
        rd(12'h080, 32'h0);
        wr(`SAH_OFF_LOW, 32'd10);
        wr(`SAH_OFF_HIGH, 32'd20);
        wr(`SAH_OFF_CTRL, 32'h1);
        rd(`SAH_OFF_WIDTH, 32'd1);
        rd(`SAH_OFF_NBKT, 32'd10);
        wr(`SAH_OFF_CTRL, 32'h0);
        wr(`SAH_OFF_LOW, 32'h100);
        wr(`SAH_OFF_HIGH, 32'h54c);
        wr(`SAH_OFF_CTRL, 32'h1);
        rd(`SAH_OFF_WIDTH, 32'd5);
        rd(`SAH_OFF_NBKT, 32'd220);
        repeat (2)
        begin
            repeat (20)
            begin
                v = 32'hf0 + $unsigned($random(seed)) % 32'd1116;
                total++;
                if (v >= 32'h100 && v < 32'h54c)
                begin
                    b = (v - 32'h100) / 5;
                    cnt[b]++;
                    if (cnt[b] > peak) peak = cnt[b];
                end
                i_sah_sampler_model.put({$random(seed), $random(seed), $random(seed), v});
            end
            i_sah_sampler_model.finish();
        end
        wr(`SAH_OFF_MARKX, 32'd3);
        wr(`SAH_OFF_MARKO, 32'd219);
        rd(`SAH_OFF_XCNT, cnt[3]);
        rd(`SAH_OFF_OCNT, cnt[219]);
        rd(`SAH_OFF_PEAK, peak);
        rd(`SAH_OFF_TOTAL, total);
        for (int i = 0; i < 224; i++) rd(12'(`SAH_OFF_BKT + 4 * i), cnt[i]);
        wr(`SAH_OFF_CTRL, 32'h11);
        rd(`SAH_OFF_TOTAL, 32'h0);
        rd(`SAH_OFF_PEAK, 32'h0);
        wr(`SAH_OFF_CTRL, 32'h3);
        @(posedge pclk);
        chk({31'h0, run_halted}, 32'h1);
        rd(`SAH_OFF_STATUS, 32'h2);
        wr(`SAH_OFF_CTRL, 32'h0);
        wr(`SAH_OFF_CTRL, 32'h1);
        @(posedge pclk);
        chk({31'h0, run_halted}, 32'h0);
        wr(`SAH_OFF_CTRL, 32'h0);
        range_run(1'b1);
        range_run(1'b0);
        wr(`SAH_OFF_SEL, 32'h0);
        rd(`SAH_OFF_RCNT, 32'h0);
        rd(`SAH_OFF_OTHER, 32'h0);
        close_out();
    end
endmodule : state_activity_histogram_tb_top
